/* File: src/nvr_bank_store.sv */
`timescale 1ns/1ps

// Nonvolatile bank array with one whole-bank write port and one byte read port.
module nvr_bank_store
  import nvr_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           wr_en,
  input  wire logic [nvr_pkg::BANK_W-1:0]     wr_bank,
  input  wire logic [nvr_pkg::BANK_BITS-1:0]  wr_data,
  input  wire logic [nvr_pkg::BANK_W-1:0]     rd_bank,
  input  wire logic [nvr_pkg::BYTE_W-1:0]     rd_byte,
  output logic      [nvr_pkg::BYTE_BITS-1:0]  rd_byte_data
);

  // The array is never touched by reset, since its contents must survive it.
  logic [BANK_BITS-1:0] mem [NUM_BANKS];

  // Contents start out erased, as a fresh part would read.
  initial begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      mem[i] = ERASED_VALUE;
    end
  end

  // Only a whole bank is ever written; there is no narrower write path.
  always_ff @(posedge clk) begin // see R05
    if (wr_en) begin
      mem[wr_bank] <= wr_data;
    end
  end

  // The byte field picks one aligned byte out of the chosen bank.
  always_comb begin // see R03, see R09
    rd_byte_data = mem[rd_bank][{rd_byte, 3'b000} +: BYTE_BITS];
  end

endmodule : nvr_bank_store

/* File: src/nvr_pkg.sv */
package nvr_pkg;

  // Storage geometry: eight banks of 128 bits, read back as 16 bytes each.
  localparam int unsigned NUM_BANKS     = 8;
  localparam int unsigned BANK_BITS     = 128;
  localparam int unsigned BYTE_BITS     = 8;
  localparam int unsigned BYTES_PER_BNK = BANK_BITS / BYTE_BITS;
  localparam int unsigned TOTAL_BITS    = NUM_BANKS * BANK_BITS;

  // Read address layout: bank in the upper three bits, byte in the lower four.
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned BANK_W        = 3;
  localparam int unsigned BYTE_W        = 4;
  localparam int unsigned BANK_LSB      = 4;
  localparam int unsigned BYTE_LSB      = 0;

  // Value a bank holds after the automatic erase.
  localparam logic [BANK_BITS-1:0] ERASED_VALUE = {BANK_BITS{1'b1}};

  // Reset value of the read data register.
  localparam logic [7:0] RD_DATA_RST = 8'h00;

  // Erase time, and the cycles it takes at the 100 MHz clock (rounded up).
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ERASE_TIME_NS = 40;
  localparam int unsigned ERASE_CYC     =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CNT_W   = 3;
  localparam logic [ERASE_CNT_W-1:0] ERASE_LAST = ERASE_CNT_W'(ERASE_CYC - 1);

  // States of the bank rewrite sequencer.
  typedef enum logic [1:0] {
    NVR_IDLE,
    NVR_ERASE,
    NVR_PROG,
    NVR_DONE
  } nvr_state_type;

endpackage : nvr_pkg

/* File: src/nvr_read_port.sv */
`timescale 1ns/1ps

// How it works
// R01: One kilobit of storage, readable any time.
// R02: Written as eight banks of 128 bits.
// R03: Each bank reads as 16 bytes.
// R04: New contents only from the scan port.
// R05: Any subset of banks, whole banks only.
// R06: Bank erased automatically before each write.
// R07: Synchronous read returns one aligned byte.
// R08: Upper three address bits pick the bank.
// R09: Lower four address bits pick the byte.
// R10: Address on rising edge, data at falling.
// R11: Every rising edge restarts the read.
// R12: Seven-bit address in, eight-bit data out.
module nvr_read_port
  import nvr_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           srst,
  input  wire logic [nvr_pkg::ADDR_W-1:0]     rd_addr,
  output logic      [nvr_pkg::BYTE_BITS-1:0]  rd_data,
  output logic                                rd_valid,
  input  wire logic                           scan_prog_req,
  input  wire logic [nvr_pkg::BANK_W-1:0]     scan_prog_bank,
  input  wire logic [nvr_pkg::BANK_BITS-1:0]  scan_prog_data,
  output logic                                scan_prog_busy,
  output logic                                scan_prog_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [ADDR_W-1:0]      addr_reg;     // Address taken at the rising edge.
  logic [ADDR_W-1:0]      addr_next;    // Next value of the address register.
  logic                   rise_tog_reg; // Flips on every rising edge.
  logic                   rise_tog_next; // Next value of the rising toggle.
  logic                   fall_tog_reg; // Follows the rising toggle at falling edges.
  logic [BYTE_BITS-1:0]   data_reg;     // Byte launched at the falling edge.
  logic [BYTE_BITS-1:0]   store_byte;   // Byte the array presents for addr_reg.
  logic [BANK_W-1:0]      rd_bank_sel;  // Bank field of the held address.
  logic [BYTE_W-1:0]      rd_byte_sel;  // Byte field of the held address.

  nvr_state_type          state_reg;    // Rewrite sequencer state.
  nvr_state_type          state_next;   // Next sequencer state.
  logic [ERASE_CNT_W-1:0] erase_cnt_reg;  // Cycles spent erasing.
  logic [ERASE_CNT_W-1:0] erase_cnt_next; // Next erase count.
  logic [BANK_W-1:0]      bank_reg;     // Bank being rewritten.
  logic [BANK_W-1:0]      bank_next;    // Next bank register value.
  logic [BANK_BITS-1:0]   pdata_reg;    // New contents held during the erase.
  logic [BANK_BITS-1:0]   pdata_next;   // Next held contents.
  logic                   wr_en;        // Whole-bank write strobe to the array.
  logic [BANK_BITS-1:0]   wr_data;      // Erase pattern or new contents.

  ////////////////////////////////////////////////////////////////////////////
  // Storage array.

  // The array is the only state that holds the kilobit; its sole write port
  // is driven by the scan-side sequencer below, never by the read side.
  nvr_bank_store u_store ( // see R01
    .clk          (clk),
    .wr_en        (wr_en),
    .wr_bank      (bank_reg),
    .wr_data      (wr_data),
    .rd_bank      (rd_bank_sel),
    .rd_byte      (rd_byte_sel),
    .rd_byte_data (store_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read port, rising-edge half.

  // Split the held address into its bank and byte fields.
  always_comb begin
    rd_bank_sel = addr_reg[BANK_LSB +: BANK_W]; // see R08
    rd_byte_sel = addr_reg[BYTE_LSB +: BYTE_W]; // see R09
  end

  // Every rising edge takes the address afresh and flips the toggle, so the
  // output goes invalid even when the address has not changed.
  always_comb begin
    addr_next     = rd_addr;        // see R10
    rise_tog_next = ~rise_tog_reg;  // see R11
  end

  // Rising-edge registers; reset is synchronous to this edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg     <= '0;
      rise_tog_reg <= 1'b0;
    end else begin
      addr_reg     <= addr_next;
      rise_tog_reg <= rise_tog_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, falling-edge half.

  // The falling edge launches the addressed byte and closes the toggle gap.
  // Reset is sampled here as well, so both halves agree after it.
  always_ff @(negedge clk) begin // see R07
    if (srst) begin
      fall_tog_reg <= 1'b0;
      data_reg     <= RD_DATA_RST;
    end else begin
      fall_tog_reg <= rise_tog_reg;
      data_reg     <= store_byte; // see R10
    end
  end

  // Valid only between a falling edge and the next rising edge. The data
  // itself is a flop output; only the valid flag is a compare of two flops.
  always_comb begin
    rd_data  = data_reg;                       // see R12
    rd_valid = (rise_tog_reg == fall_tog_reg); // see R11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan-side rewrite sequencer.

  // A request names one bank; any subset is rewritten by issuing one request
  // per bank. The bank is first erased, then written whole.
  always_comb begin
    state_next     = state_reg;
    erase_cnt_next = erase_cnt_reg;
    bank_next      = bank_reg;
    pdata_next     = pdata_reg;
    wr_en          = 1'b0;
    wr_data        = ERASED_VALUE;
    case (state_reg)
      NVR_IDLE: begin
        // New contents enter only here, from the scan port.
        if (scan_prog_req) begin // see R04
          bank_next      = scan_prog_bank;
          pdata_next     = scan_prog_data;
          erase_cnt_next = '0;
          state_next     = NVR_ERASE;
        end
      end
      NVR_ERASE: begin
        // The erase needs no request of its own; it is part of every write.
        wr_en          = (erase_cnt_reg == '0); // see R06
        wr_data        = ERASED_VALUE;
        erase_cnt_next = erase_cnt_reg + 1'b1;
        if (erase_cnt_reg == ERASE_LAST) begin
          state_next = NVR_PROG;
        end
      end
      NVR_PROG: begin
        // All 128 bits of the bank are written in one go.
        wr_en      = 1'b1; // see R02
        wr_data    = pdata_reg;
        state_next = NVR_DONE;
      end
      NVR_DONE: begin
        state_next = NVR_IDLE;
      end
      default: begin
        state_next = NVR_IDLE;
      end
    endcase
  end

  // Sequencer registers. The held data is not reset since it is only read
  // after a request has loaded it.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= NVR_IDLE;
      erase_cnt_reg <= '0;
      bank_reg      <= '0;
    end else begin
      state_reg     <= state_next;
      erase_cnt_reg <= erase_cnt_next;
      bank_reg      <= bank_next;
    end
    pdata_reg <= pdata_next;
  end

  // Busy while a rewrite is under way; done pulses for one cycle at the end.
  always_comb begin
    scan_prog_busy = (state_reg != NVR_IDLE);
    scan_prog_done = (state_reg == NVR_DONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // The byte launched at a falling edge is the byte the held address names.
  read_byte_a: assert property (@(posedge clk) disable iff (srst) // see R07
    !$past(srst) |-> (rd_valid && rd_data == store_byte))
    else $error("read byte does not match the addressed byte");

  // The address taken is the one presented at the previous rising edge.
  addr_take_a: assert property (@(posedge clk) disable iff (srst) // see R10
    !$past(srst) |-> addr_reg == $past(rd_addr))
    else $error("read address not taken at the rising edge");

  // Bank and byte fields come from the upper three and lower four bits.
  addr_split_a: assert property (@(posedge clk) disable iff (srst) // see R08
    {rd_bank_sel, rd_byte_sel} == addr_reg)
    else $error("address split into wrong bank and byte fields");

  // Every rising edge restarts the read, even for a repeated address.
  read_restart_a: assert property (@(posedge clk) disable iff (srst) // see R11
    !$past(srst) |-> rise_tog_reg != $past(rise_tog_reg))
    else $error("rising edge did not restart the read");

  // A program write is always preceded by a full erase of the bank.
  erase_first_a: assert property (@(posedge clk) disable iff (srst) // see R06
    $rose(state_reg == NVR_ERASE) |-> (state_reg == NVR_ERASE)[*4] ##1
      (state_reg == NVR_PROG && wr_en && wr_data == pdata_reg))
    else $error("bank not erased for the full time before programming");

  // The erase itself writes the erased pattern into the chosen bank.
  erase_write_a: assert property (@(posedge clk) disable iff (srst) // see R06
    $rose(state_reg == NVR_ERASE) |-> wr_en && wr_data == ERASED_VALUE)
    else $error("erase did not clear the bank");

  // The array is only written by the scan sequencer, never by a read.
  write_source_a: assert property (@(posedge clk) disable iff (srst) // see R04
    wr_en |-> (state_reg == NVR_ERASE || state_reg == NVR_PROG))
    else $error("array written outside a scan rewrite");

  // A request taken while idle rewrites exactly the requested bank.
  bank_hold_a: assert property (@(posedge clk) disable iff (srst) // see R05
    (state_reg == NVR_IDLE && scan_prog_req) |=> scan_prog_busy &&
      bank_reg == $past(scan_prog_bank) ##5 scan_prog_done ##1 !scan_prog_busy)
    else $error("rewrite did not complete on the requested bank");

endmodule : nvr_read_port

/* File: tb/nvr_read_port_tb_top.sv */
`timescale 1ns/1ps

// Bench for the read port: reset, erased reads and bank rewrites.
module nvr_read_port_tb_top;
  import nvr_pkg::*;

  localparam logic [127:0] PAT_A = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  localparam logic [127:0] PAT_B = 128'h1f2e_3d4c_5b6a_7988_97a6_b5c4_d3e2_f100;

  logic         clk;            // Bench clock.
  logic         srst;           // Synchronous reset.
  logic [6:0]   rd_addr;        // Address from the model.
  logic [7:0]   rd_data;        // Byte read back.
  logic         rd_valid;       // Byte valid flag.
  logic         scan_prog_req;  // Rewrite request.
  logic [2:0]   scan_prog_bank; // Bank to rewrite.
  logic [127:0] scan_prog_data; // New bank contents.
  logic         scan_prog_busy; // Rewrite in progress.
  logic         scan_prog_done; // Rewrite finished.
  int           n_tests = 0;    // Comparisons made.
  int           n_mismatch = 0; // Comparisons failed.
  int           n_cyc = 0;      // Cycles run, for the hang limit.

  nvr_read_port u_nvr_read_port (
    .clk(clk), .srst(srst), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .scan_prog_req(scan_prog_req), .scan_prog_bank(scan_prog_bank),
    .scan_prog_data(scan_prog_data), .scan_prog_busy(scan_prog_busy),
    .scan_prog_done(scan_prog_done)
  );

  nvr_user_model u_nvr_user_model (
    .clk(clk), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang is cut short well above the hundred or so cycles the tests need.
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 1000) begin
      n_mismatch++;
      results();
    end
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One read through the model, judging valid after both edges.
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       lo;
    logic       hi;
    u_nvr_user_model.fetch(a, d, lo, hi);
    check(lo, 1'b0);
    check(hi, 1'b1);
    check(d, exp);
  endtask : rd

  // Rewrite one bank; a second request lands while busy and must be dropped.
  task automatic prog(input logic [2:0] bank, input logic [127:0] data, input logic [2:0] extra);
    int n_busy;
    int at_done;
    n_busy = 0;
    at_done = 0;
    @(negedge clk);
    scan_prog_req = 1'b1;
    scan_prog_bank = bank;
    scan_prog_data = data;
    for (int i = 1; i <= 9; i++) begin
      @(negedge clk);
      scan_prog_req = (i == 2);
      scan_prog_bank = (i == 2) ? extra : bank;
      if (scan_prog_busy === 1'b1) n_busy++;
      if (scan_prog_done === 1'b1) at_done += i;
    end
    check(n_busy, 6);
    check(at_done, 6);
  endtask : prog

  // Reset is held through three falling edges, then released by a non-blocking write. The
  // falling-edge half samples reset at this same edge, so a blocking write
  // would race it. The reset values still stand just after the release.
  task automatic t_reset();
    repeat (3) @(negedge clk);
    srst <= 1'b0;
    #1;
    check(rd_data, 8'h00);
    check(rd_valid, 1'b1);
    check({scan_prog_busy, scan_prog_done}, 2'b00);
    $display("test reset done");
  endtask : t_reset

  // Every bank reads erased before any rewrite.
  task automatic t_erased();
    for (int b = 0; b < 8; b++) rd({3'(b), 4'(15 - b)}, 8'hff);
    $display("test erased done");
  endtask : t_erased

  // Two rewrites of one bank; neighbours stay erased, mid-rewrite reads erased.
  task automatic t_rewrite();
    prog(3'd5, PAT_A, 3'd6);
    for (int b = 0; b < 16; b++) rd({3'd5, 4'(b)}, PAT_A[8*b +: 8]);
    rd(7'h4f, 8'hff);
    fork
      prog(3'd5, PAT_B, 3'd6);
      begin
        repeat (2) @(negedge clk);
        rd(7'h53, 8'hff);
      end
    join
    for (int b = 0; b < 16; b++) rd({3'd5, 4'(b)}, PAT_B[8*b +: 8]);
    rd(7'h60, 8'hff);
    rd(7'h60, 8'hff);
    $display("test rewrite done");
  endtask : t_rewrite

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Main sequence.
  initial begin
    srst = 1'b1;
    scan_prog_req = 1'b0;
    scan_prog_bank = 3'h0;
    scan_prog_data = '0;
    t_reset();
    t_erased();
    t_rewrite();
    results();
  end

endmodule : nvr_read_port_tb_top

/* File: tb/nvr_user_model.sv */
`timescale 1ns/1ps

// Fabric-side reader: it presents one address and collects the byte.
module nvr_user_model
  import nvr_pkg::*;
(
  input  wire logic                           clk,
  output logic      [nvr_pkg::ADDR_W-1:0]     rd_addr,
  input  wire logic [nvr_pkg::BYTE_BITS-1:0]  rd_data,
  input  wire logic                           rd_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // The address starts at zero so the port never takes an unknown.
  initial begin
    rd_addr = '0;
  end

  // The address moves only at a falling edge, so it is stable at the rising
  // edge that takes it. Valid is sampled after both edges.
  task automatic fetch(
    input  logic [nvr_pkg::ADDR_W-1:0]    addr,
    output logic [nvr_pkg::BYTE_BITS-1:0] data,
    output logic                          lo,
    output logic                          hi
  );
    @(negedge clk);
    rd_addr <= addr;
    @(posedge clk);
    #1;
    lo = rd_valid;
    @(negedge clk);
    #1;
    hi = rd_valid;
    data = rd_data;
  endtask : fetch

endmodule : nvr_user_model
